/* File: dv/bsf_master.sv */
`timescale 1ns/1ps
// bus master standing in for the sequencer
module bsf_master (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  output logic             rready
);
  // idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    // one edge passes so the next call never re-drives in this step
    @(posedge aclk);
  endtask

  // read held until taken; the bench checks the answer
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

/* File: dv/test_bit_shift_flag_datapath.sv */
`timescale 1ns/1ps
// self-checking bench for the shift, bit and flag datapath
module test_bit_shift_flag_datapath;
  localparam logic [7:0] A_CM = bsf_pkg::ADDR_CMD;
  localparam logic [7:0] A_WK = bsf_pkg::ADDR_WORK;
  localparam logic [7:0] A_SR = bsf_pkg::ADDR_SRC;
  localparam logic [7:0] A_FL = bsf_pkg::ADDR_FLAGS;
  localparam logic [7:0] A_IO = bsf_pkg::ADDR_IO;
  localparam logic [7:0] A_SP = bsf_pkg::ADDR_SP;
  logic [7:0]  awaddr, araddr, flags_port, io_port;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, resp, rresp;
  logic [1:0]  rresp_exp = bsf_pkg::RESP_OKAY;
  logic        aclk, aresetn, busy;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          mismatches = 0;
  int          num_checks = 0;
  int          busy_cnt = 0;
  integer      seed = 32'h93F8;

  bsf_datapath dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .status_flags_word(flags_port),
    .io_reg_value(io_port), .busy(busy)
  );

  bsf_master m (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready)
  );

  // clock at 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // note the expected word, then issue the read
  task automatic rexp(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    name_q.push_back(nm);
    m.rd(a);
  endtask

  // write a register and expect an okay answer
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    m.wr(a, d, r);
    chk("bresp", {30'h0, bsf_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  // wait until a stack operation has finished
  task automatic idle;
    while (busy !== 1'b0) @(posedge aclk);
  endtask

  // oldest note against each read answer; busy cycle count
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      chk(name_q.pop_front(), exp_q.pop_front(), rdata);
      chk("rresp", {30'h0, rresp_exp}, {30'h0, rresp});
    end
    if (busy === 1'b1) busy_cnt++;
  end

  // expected {io, flags, work} after one single-cycle operation
  function automatic logic [23:0] ref_op(logic [4:0] op, logic [7:0] w,
      logic [7:0] f, logic [7:0] s, logic [7:0] io, logic [2:0] b);
    logic [7:0] r;
    logic       c;
    logic       sh;
    r = w;
    c = f[0];
    sh = 1'b1;
    case (op)
      5'h04: {c, r} = {w, 1'b0};
      5'h05: {r, c} = {1'b0, w};
      5'h06: {c, r} = {w, f[0]};
      5'h07: {r, c} = {f[0], w};
      5'h08: {r, c} = {w[7], w};
      default: sh = 1'b0;
    endcase
    if (sh) f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    case (op)
      5'h02: io[b] = 1'b1;
      5'h03: io[b] = 1'b0;
      5'h09: r = {w[3:0], w[7:4]};
      5'h0A: f[b] = 1'b1;
      5'h0B: f[b] = 1'b0;
      5'h0C: f[6] = s[b];
      5'h0D: r[b] = f[6];
      5'h0E: f[0] = 1'b1;
      5'h0F: f[0] = 1'b0;
      5'h10: f[2] = 1'b1;
      5'h11: f[2] = 1'b0;
      5'h12: f[1] = 1'b1;
      5'h13: f[1] = 1'b0;
      default: ;
    endcase
    return {io, f, r};
  endfunction

  // one single-cycle operation on random operands
  task automatic run_op(input logic [4:0] op);
    logic [7:0]  w, f, s, io;
    logic [2:0]  b;
    logic [23:0] e;
    w = 8'($random(seed));
    f = 8'($random(seed));
    s = 8'($random(seed));
    io = 8'($random(seed));
    b = 3'($random(seed));
    wreg(A_WK, {24'h0, w});
    wreg(A_FL, {24'h0, f});
    wreg(A_SR, {24'h0, s});
    wreg(A_IO, {24'h0, io});
    e = ref_op(op, w, f, s, io, b);
    wreg(A_CM, {21'h0, b, 3'h0, op});
    rexp("work", A_WK, e[7:0]);
    rexp("flags", A_FL, e[15:8]);
    rexp("io", A_IO, e[23:16]);
    chk("ports", {16'h0, e[23:8]}, {16'h0, io_port, flags_port});
  endtask

  // run summary and verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rexp("work_rst", A_WK, bsf_pkg::WORK_RST);
    rexp("flags_rst", A_FL, bsf_pkg::FLAGS_RST);
    rexp("io_rst", A_IO, bsf_pkg::IO_RST);
    rexp("sp_rst", A_SP, {4'h0, bsf_pkg::SP_RST});
    $display("test reset values done");
    for (int i = 0; i < 36; i++) run_op(5'(2 + i % 18));
    $display("test single-cycle ops done");
    busy_cnt = 0;
    wreg(A_SR, 32'h0000005A);
    wreg(A_CM, 32'h00000000);
    idle();
    wreg(A_SR, 32'h000000A5);
    wreg(A_CM, 32'h00000000);
    idle();
    wreg(A_CM, 32'h00000001);
    idle();
    rexp("pop_last", A_WK, 8'hA5);
    wreg(A_CM, 32'h00000001);
    idle();
    rexp("pop_first", A_WK, 8'h5A);
    rexp("sp_back", A_SP, 8'h0F);
    rexp("cmd_back", A_CM, 8'h01);
    chk("busy_cycles", 32'h8, busy_cnt);
    $display("test stack done");
    m.wr(8'h3C, 32'h000000FF, resp);
    chk("bresp_unmapped", {30'h0, bsf_pkg::RESP_SLVERR}, {30'h0, resp});
    rresp_exp = bsf_pkg::RESP_SLVERR;
    rexp("unmapped", 8'h3C, 8'h00);
    $display("test unmapped done");
    end_of_test();
  end
endmodule

/* File: rtl/bsf_bit_force.sv */
`timescale 1ns/1ps
module bsf_bit_force #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         value,
  input  wire logic [$clog2(W)-1:0] idx,
  input  wire logic                 bit_val,
  output logic      [W-1:0]         result
);

  // force one selected bit, keep the others
  always_comb begin
    result      = value;
    result[idx] = bit_val;
  end

endmodule

/* File: rtl/bsf_datapath.sv */
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - push stores source on stack, pop loads work register; both two cycles.
// - io set forces selected io bit to 1, io clear to 0.
// - logical shift up moves bits up, zero enters bit 0.
// - logical shift down moves bits down, zero enters bit 7.
// - rotate up through carry: carry into bit 0, bit 7 to carry.
// - rotate down through carry: carry into bit 7, bit 0 to carry.
// - signed shift down moves bits down, bit 7 kept.
// - shifts and rotates update zero, carry, negative and overflow flags.
// - nibble swap exchanges halves, no flag changes.
// - status set or clear forces the indexed flag bit.
// - bit store copies selected source bit into transfer flag only.
// - bit load copies transfer flag into selected work bit only.
// - carry set or clear in one cycle, no other flag.
// - negative set or clear in one cycle, no other flag.
// - zero set or clear in one cycle, no other flag.
module bsf_datapath (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       status_flags_word,
  output logic [7:0]       io_reg_value,
  output logic             busy
);

  logic                aw_held_q;
  logic [7:0]          aw_addr_q;
  logic                w_held_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  logic [31:0]         rdata_q;
  logic                wr_fire;
  logic                wr_err;
  logic                sw_wr;
  logic                cmd_go;
  bsf_pkg::bsf_op_e    cmd_op;
  logic [2:0]          cmd_bit;
  logic [10:0]         last_cmd_q;
  logic [7:0]          work_q;
  logic [7:0]          src_q;
  logic [7:0]          flags_q;
  logic [7:0]          io_q;
  logic [3:0]          sp_q;
  logic [7:0]          stack_mem [bsf_pkg::STACK_DEPTH];
  bsf_pkg::bsf_stk_e   stk_q;
  logic                stk_push_q;
  logic                stk_done;
  logic [3:0]          sp_next;
  bsf_pkg::bsf_shift_s sh;
  logic                is_shift;
  logic                is_flag_op;
  logic [2:0]          flag_idx;
  logic                flag_val;
  logic [7:0]          io_forced;
  logic [7:0]          work_forced;
  logic [7:0]          flags_forced;
  logic [31:0]         rd_word;
  logic                rd_err;

  // write channel handshakes, address and data taken in any order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;

  // outputs mirror internal state
  assign status_flags_word = flags_q;
  assign io_reg_value      = io_q;
  assign busy              = (stk_q != bsf_pkg::STK_IDLE);

  // command decode, lane 1 carries the bit index
  assign cmd_op  = bsf_pkg::bsf_op_e'(w_data_q[bsf_pkg::CMD_OP_LSB +: 5]);
  assign cmd_bit = w_strb_q[1] ? w_data_q[bsf_pkg::CMD_BIT_LSB +: 3] : 3'h0;
  assign cmd_go  = wr_fire && (aw_addr_q == bsf_pkg::ADDR_CMD)
                   && w_strb_q[0] && !busy;
  assign sw_wr   = wr_fire && w_strb_q[0];

  // address latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // data latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // write error: unmapped, or command while stack op runs
  always_comb begin
    if (aw_addr_q == bsf_pkg::ADDR_CMD) begin
      wr_err = busy;
    end else if (aw_addr_q == bsf_pkg::ADDR_WORK ||
                 aw_addr_q == bsf_pkg::ADDR_SRC ||
                 aw_addr_q == bsf_pkg::ADDR_FLAGS ||
                 aw_addr_q == bsf_pkg::ADDR_IO ||
                 aw_addr_q == bsf_pkg::ADDR_SP) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= bsf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_err ? bsf_pkg::RESP_SLVERR : bsf_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_err  = 1'b0;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == bsf_pkg::ADDR_CMD) begin
      rd_word[10:0]                 = last_cmd_q;
      rd_word[bsf_pkg::CMD_BUSY_BIT] = busy;
    end else if (s_axi_araddr == bsf_pkg::ADDR_WORK) begin
      rd_word[7:0] = work_q;
    end else if (s_axi_araddr == bsf_pkg::ADDR_SRC) begin
      rd_word[7:0] = src_q;
    end else if (s_axi_araddr == bsf_pkg::ADDR_FLAGS) begin
      rd_word[7:0] = flags_q;
    end else if (s_axi_araddr == bsf_pkg::ADDR_IO) begin
      rd_word[7:0] = io_q;
    end else if (s_axi_araddr == bsf_pkg::ADDR_SP) begin
      rd_word[3:0] = sp_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= bsf_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_err ? bsf_pkg::RESP_SLVERR : bsf_pkg::RESP_OKAY;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // last accepted command, for readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cmd_q <= 11'h000;
    end else if (cmd_go) begin
      last_cmd_q <= {cmd_bit, 3'h0, cmd_op};
    end
  end

  bsf_shift_unit u_shift (
    .op       (cmd_op),
    .value    (work_q),
    .carry_in (flags_q[bsf_pkg::FLG_C]),
    .result   (sh)
  );

  // io bit set or clear
  bsf_bit_force #(.W(8)) u_io_bit (
    .value   (io_q),
    .idx     (cmd_bit),
    .bit_val (cmd_op == bsf_pkg::OP_IO_SET),
    .result  (io_forced)
  );

  // transfer flag into working register bit
  bsf_bit_force #(.W(8)) u_work_bit (
    .value   (work_q),
    .idx     (cmd_bit),
    .bit_val (flags_q[bsf_pkg::FLG_T]),
    .result  (work_forced)
  );

  // every single-flag op goes through one forcing path
  bsf_bit_force #(.W(8)) u_flag_bit (
    .value   (flags_q),
    .idx     (flag_idx),
    .bit_val (flag_val),
    .result  (flags_forced)
  );

  // which flag and which value
  always_comb begin
    is_shift   = 1'b0;
    is_flag_op = 1'b1;
    flag_idx   = cmd_bit;
    flag_val   = 1'b0;
    case (cmd_op)
      bsf_pkg::OP_SHL, bsf_pkg::OP_SHR, bsf_pkg::OP_ROL,
      bsf_pkg::OP_ROR, bsf_pkg::OP_ASR: begin
        is_shift   = 1'b1;
        is_flag_op = 1'b0;
      end
      bsf_pkg::OP_STAT_SET: flag_val = 1'b1;
      bsf_pkg::OP_STAT_CLR: flag_val = 1'b0;
      bsf_pkg::OP_BIT_TO_T: begin
        flag_idx = bsf_pkg::FLG_T;
        flag_val = src_q[cmd_bit];
      end
      bsf_pkg::OP_C_SET: begin
        flag_idx = bsf_pkg::FLG_C;
        flag_val = 1'b1;
      end
      bsf_pkg::OP_C_CLR: flag_idx = bsf_pkg::FLG_C;
      bsf_pkg::OP_N_SET: begin
        flag_idx = bsf_pkg::FLG_N;
        flag_val = 1'b1;
      end
      bsf_pkg::OP_N_CLR: flag_idx = bsf_pkg::FLG_N;
      bsf_pkg::OP_Z_SET: begin
        flag_idx = bsf_pkg::FLG_Z;
        flag_val = 1'b1;
      end
      bsf_pkg::OP_Z_CLR: flag_idx = bsf_pkg::FLG_Z;
      default: is_flag_op = 1'b0;
    endcase
  end

  // stack sequencer: accept, then two busy cycles
  assign stk_done = (stk_q == bsf_pkg::STK_SECOND);
  assign sp_next  = sp_q + 4'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stk_q      <= bsf_pkg::STK_IDLE;
      stk_push_q <= 1'b0;
    end else begin
      case (stk_q)
        bsf_pkg::STK_IDLE: begin
          if (cmd_go && (cmd_op == bsf_pkg::OP_PUSH ||
                         cmd_op == bsf_pkg::OP_POP)) begin
            stk_q      <= bsf_pkg::STK_FIRST;
            stk_push_q <= (cmd_op == bsf_pkg::OP_PUSH);
          end
        end
        bsf_pkg::STK_FIRST: stk_q <= bsf_pkg::STK_SECOND;
        default:            stk_q <= bsf_pkg::STK_IDLE;
      endcase
    end
  end

  // stack storage, written at the end of a push
  always_ff @(posedge aclk) begin
    if (stk_done && stk_push_q) begin
      stack_mem[sp_q] <= src_q;
    end
  end

  // stack pointer, post-decrement push, pre-increment pop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= bsf_pkg::SP_RST;
    end else if (stk_done) begin
      sp_q <= stk_push_q ? sp_q - 4'h1 : sp_next;
    end else if (sw_wr && aw_addr_q == bsf_pkg::ADDR_SP && !busy) begin
      sp_q <= w_data_q[3:0];
    end
  end

  // working register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      work_q <= bsf_pkg::WORK_RST;
    end else if (stk_done && !stk_push_q) begin
      work_q <= stack_mem[sp_next];
    end else if (cmd_go && (is_shift || cmd_op == bsf_pkg::OP_SWAP)) begin
      work_q <= sh.res;
    end else if (cmd_go && cmd_op == bsf_pkg::OP_T_TO_BIT) begin
      work_q <= work_forced;
    end else if (sw_wr && aw_addr_q == bsf_pkg::ADDR_WORK) begin
      work_q <= w_data_q[7:0];
    end
  end

  // source register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= bsf_pkg::SRC_RST;
    end else if (sw_wr && aw_addr_q == bsf_pkg::ADDR_SRC) begin
      src_q <= w_data_q[7:0];
    end
  end

  // status flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= bsf_pkg::FLAGS_RST;
    end else if (cmd_go && is_shift) begin
      flags_q[bsf_pkg::FLG_C] <= sh.c;
      flags_q[bsf_pkg::FLG_Z] <= sh.z;
      flags_q[bsf_pkg::FLG_N] <= sh.n;
      flags_q[bsf_pkg::FLG_V] <= sh.v;
    end else if (cmd_go && is_flag_op) begin
      flags_q <= flags_forced;
    end else if (sw_wr && aw_addr_q == bsf_pkg::ADDR_FLAGS) begin
      flags_q <= w_data_q[7:0];
    end
  end

  // io register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_q <= bsf_pkg::IO_RST;
    end else if (cmd_go && (cmd_op == bsf_pkg::OP_IO_SET ||
                            cmd_op == bsf_pkg::OP_IO_CLR)) begin
      io_q <= io_forced;
    end else if (sw_wr && aw_addr_q == bsf_pkg::ADDR_IO) begin
      io_q <= w_data_q[7:0];
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stack_two_cycles: assert property (
    cmd_go && (cmd_op == bsf_pkg::OP_PUSH || cmd_op == bsf_pkg::OP_POP)
    |=> busy [*2] ##1 !busy) else $error("stack op not two cycles");
  a_push_stored: assert property (
    stk_done && stk_push_q |=> stack_mem[sp_next] == $past(src_q))
    else $error("push lost data");
  a_io_bit_set: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_IO_SET
    |=> io_q == ($past(io_q) | (8'h01 << $past(cmd_bit))))
    else $error("io set wrong");
  a_io_bit_clear: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_IO_CLR
    |=> io_q == ($past(io_q) & ~(8'h01 << $past(cmd_bit))))
    else $error("io clear wrong");
  a_shift_up_res: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_SHL
    |=> work_q == {$past(work_q[6:0]), 1'b0} && flags_q[0] == $past(work_q[7]))
    else $error("shift up wrong");
  a_shift_down_res: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_SHR
    |=> work_q == {1'b0, $past(work_q[7:1])} && flags_q[0] == $past(work_q[0]))
    else $error("shift down wrong");
  a_rotate_up_res: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_ROL
    |=> work_q == {$past(work_q[6:0]), $past(flags_q[0])}
        && flags_q[0] == $past(work_q[7])) else $error("rotate up wrong");
  a_rotate_down_res: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_ROR
    |=> work_q == {$past(flags_q[0]), $past(work_q[7:1])}
        && flags_q[0] == $past(work_q[0])) else $error("rotate down wrong");
  a_signed_shift: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_ASR
    |=> work_q == {$past(work_q[7]), $past(work_q[7:1])})
    else $error("signed shift wrong");
  a_shift_flags: assert property (
    cmd_go && is_shift |=> flags_q[1] == (work_q == 8'h00)
    && flags_q[2] == work_q[7] && flags_q[3] == (work_q[7] ^ flags_q[0])
    && flags_q[7:4] == $past(flags_q[7:4])) else $error("shift flags wrong");
  a_swap_nibbles: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_SWAP
    |=> work_q == {$past(work_q[3:0]), $past(work_q[7:4])}
        && $stable(flags_q)) else $error("swap wrong");
  a_status_bit: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_STAT_SET
    |=> flags_q == ($past(flags_q) | (8'h01 << $past(cmd_bit))))
    else $error("status set wrong");
  a_bit_to_t: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_BIT_TO_T |=> flags_q[6] ==
    $past(src_q[cmd_bit]) && {flags_q[7], flags_q[5:0]} ==
    $past({flags_q[7], flags_q[5:0]})) else $error("bit store wrong");
  a_t_to_bit: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_T_TO_BIT |=> $stable(flags_q)
    && work_q[$past(cmd_bit)] == flags_q[6]
    && ((work_q ^ $past(work_q)) & ~(8'h01 << $past(cmd_bit))) == 8'h00)
    else $error("bit load wrong");
  a_carry_ops: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_C_SET
    |=> flags_q == {$past(flags_q[7:1]), 1'b1}) else $error("carry set wrong");
  a_neg_ops: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_N_CLR
    |=> flags_q == ($past(flags_q) & 8'hFB)) else $error("neg clear wrong");
  a_zero_ops: assert property (
    cmd_go && cmd_op == bsf_pkg::OP_Z_SET
    |=> flags_q == ($past(flags_q) | 8'h02)) else $error("zero set wrong");

  c_push_pop: cover property (
    stk_done && stk_push_q ##[1:20] stk_done && !stk_push_q);
  c_rotate_carry: cover property (
    cmd_go && cmd_op == bsf_pkg::OP_ROL && flags_q[0]);
  c_refused_cmd: cover property (wr_fire && wr_err && busy);

endmodule

/* File: rtl/bsf_pkg.sv */
package bsf_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_WORK  = 8'h04;
  localparam logic [7:0] ADDR_SRC   = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_IO    = 8'h10;
  localparam logic [7:0] ADDR_SP    = 8'h14;

  // command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BIT_LSB  = 8;
  localparam int CMD_BUSY_BIT = 31;

  // status flag positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_T = 3'h6;

  // values after reset
  localparam logic [7:0] WORK_RST  = 8'h00;
  localparam logic [7:0] SRC_RST   = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IO_RST    = 8'h00;
  localparam logic [3:0] SP_RST    = 4'hF;
  localparam int         STACK_DEPTH = 16;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_PUSH     = 5'b00000,
    OP_POP      = 5'b00001,
    OP_IO_SET   = 5'b00010,
    OP_IO_CLR   = 5'b00011,
    OP_SHL      = 5'b00100,
    OP_SHR      = 5'b00101,
    OP_ROL      = 5'b00110,
    OP_ROR      = 5'b00111,
    OP_ASR      = 5'b01000,
    OP_SWAP     = 5'b01001,
    OP_STAT_SET = 5'b01010,
    OP_STAT_CLR = 5'b01011,
    OP_BIT_TO_T = 5'b01100,
    OP_T_TO_BIT = 5'b01101,
    OP_C_SET    = 5'b01110,
    OP_C_CLR    = 5'b01111,
    OP_N_SET    = 5'b10000,
    OP_N_CLR    = 5'b10001,
    OP_Z_SET    = 5'b10010,
    OP_Z_CLR    = 5'b10011
  } bsf_op_e;

  typedef enum logic [1:0] {
    STK_IDLE   = 2'b00,
    STK_FIRST  = 2'b01,
    STK_SECOND = 2'b10
  } bsf_stk_e;

  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       z;
    logic       n;
    logic       v;
  } bsf_shift_s;

endpackage

/* File: rtl/bsf_shift_unit.sv */
`timescale 1ns/1ps
module bsf_shift_unit (
  input  wire bsf_pkg::bsf_op_e  op,
  input  wire logic [7:0]        value,
  input  wire logic              carry_in,
  output bsf_pkg::bsf_shift_s    result
);

  // shifted value and bit pushed out
  always_comb begin
    result.res = value;
    result.c   = carry_in;
    case (op)
      bsf_pkg::OP_SHL: begin
        result.res = {value[6:0], 1'b0};
        result.c   = value[7];
      end
      bsf_pkg::OP_SHR: begin
        result.res = {1'b0, value[7:1]};
        result.c   = value[0];
      end
      bsf_pkg::OP_ROL: begin
        result.res = {value[6:0], carry_in};
        result.c   = value[7];
      end
      bsf_pkg::OP_ROR: begin
        result.res = {carry_in, value[7:1]};
        result.c   = value[0];
      end
      bsf_pkg::OP_ASR: begin
        result.res = {value[7], value[7:1]};
        result.c   = value[0];
      end
      bsf_pkg::OP_SWAP: begin
        result.res = {value[3:0], value[7:4]};
      end
      default: begin
        result.res = value;
      end
    endcase
    // flags follow the result
    result.z = (result.res == 8'h00);
    result.n = result.res[7];
    result.v = result.res[7] ^ result.c;
  end

endmodule
